// File: rtl/bs_boot_sequencer.sv
`timescale 1ns/100ps
module bs_boot_sequencer import bs_pkg::*; #(
   parameter int BOOT_LIMIT = BOOT_LIMIT_CYC
) (
   // Clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Straps and power status.
   input wire logic i_external_supply_select,
   input wire logic i_strap_boot,
   input wire logic [1:0] i_strap_clk,
   input wire logic i_supply_good,
   input wire logic i_pll_locked,
   // Host bus interface detection and download.
   input wire logic i_host_bus_interface_sclk,
   input wire logic i_host_bus_interface_i2c_start,
   input wire logic i_host_valid,
   input wire logic i_host_cfg,
   input wire logic [DATA_W-1:0] i_host_data,
   input wire logic i_host_done,
   // Flash reader.
   input wire logic i_flash_valid,
   input wire logic i_flash_cfg,
   input wire logic [DATA_W-1:0] i_flash_data,
   input wire logic i_flash_last,
   // Power and clock control.
   output logic o_core_reg_en,
   output logic o_pll_en,
   output logic [1:0] o_pll_ref_sel,
   // Boot status.
   output logic [2:0] o_boot_sense,
   output logic o_flash_read,
   output logic o_hbi_spi_mode,
   output logic o_boot_master_set,
   output logic o_boot_master_spi,
   output logic o_boot_timeout,
   output logic o_run,
   // Events and host interrupt pin.
   output logic o_event_valid,
   output logic [3:0] o_event_code,
   output logic o_host_interrupt_out_n,
   output logic o_host_interrupt_out_oe,
   // Program RAM and configuration register writes.
   output logic o_pram_we,
   output logic [PRAM_AW-1:0] o_pram_addr,
   output logic o_cfg_we,
   output logic [CFG_AW-1:0] o_cfg_addr,
   output logic [DATA_W-1:0] o_wr_data,
   output logic o_cfg_commit
);
   // ------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------
   bs_state_t state;
   logic external_supply_select_q;
   logic sclk_q;
   logic [1:0] sclk_edges;
   logic [BOOT_CNT_W-1:0] boot_cnt;
   logic sclk_rise;
   logic auto_boot;
   logic wr_valid;
   logic wr_cfg;
   logic [DATA_W-1:0] wr_word;
   logic [PRAM_AW-1:0] next_pram_addr;
   logic [CFG_AW-1:0] next_cfg_addr;
   localparam logic [BOOT_CNT_W-1:0] BOOT_LAST =
      BOOT_CNT_W'(BOOT_LIMIT - 1);

   assign sclk_rise = i_host_bus_interface_sclk & ~sclk_q;
   assign auto_boot = o_boot_sense[SENSE_BOOT_BIT];

   // ------------------------------------------------------------
   // Image write mux.
   // ------------------------------------------------------------
   // Words come from Flash in auto boot and from the host otherwise.
   always_comb begin
      if (state == S_FLASH) begin // see R1
         wr_valid = i_flash_valid;
         wr_cfg = i_flash_cfg;
         wr_word = i_flash_data;
      end else if (state == S_HOST) begin // see R21
         wr_valid = i_host_valid;
         wr_cfg = i_host_cfg;
         wr_word = i_host_data;
      end else begin
         wr_valid = 1'b0;
         wr_cfg = 1'b0;
         wr_word = '0;
      end
      next_pram_addr = o_pram_we ? o_pram_addr + 1'b1 : o_pram_addr;
      next_cfg_addr = o_cfg_we ? o_cfg_addr + 1'b1 : o_cfg_addr;
   end

   // ------------------------------------------------------------
   // Boot sequencer.
   // ------------------------------------------------------------
   // Straps are caught by a clocked step after release, never by reset.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin // see R17
         state <= S_STRAP;
         external_supply_select_q <= 1'b1;
         o_boot_sense <= SENSE_RST;
         o_core_reg_en <= 1'b0;
         o_pll_en <= 1'b0;
         o_pll_ref_sel <= CLK_XTAL;
         o_flash_read <= 1'b0;
         o_cfg_commit <= 1'b0;
         o_run <= 1'b0;
         o_event_valid <= 1'b0;
         o_event_code <= EV_NONE;
         o_host_interrupt_out_n <= 1'b1;
         o_host_interrupt_out_oe <= 1'b0;
      end else if (i_ce) begin
         o_event_valid <= 1'b0;
         o_cfg_commit <= 1'b0;
         case (state)
            S_STRAP: begin
               o_boot_sense <= {i_strap_boot, i_strap_clk}; // see R18, R2
               external_supply_select_q <= i_external_supply_select;
               o_host_interrupt_out_oe <= 1'b1;
               o_core_reg_en <= ~i_external_supply_select; // see R10
               if (i_strap_clk == CLK_RSVD) begin // see R22
                  o_pll_ref_sel <= CLK_XTAL;
                  o_event_valid <= 1'b1;
                  o_event_code <= EV_CLK_FALLBACK;
               end else begin
                  o_pll_ref_sel <= i_strap_clk; // see R19, R12
               end
               state <= S_SUPPLY;
            end
            S_SUPPLY: begin
               if (i_supply_good) begin // see R11
                  o_pll_en <= 1'b1;
                  state <= S_PLL;
               end
            end
            S_PLL: begin
               if (i_pll_locked) begin // see R12, R13
                  o_event_valid <= 1'b1;
                  o_event_code <= EV_READY;
                  o_host_interrupt_out_n <= 1'b0;
                  state <= S_READY;
               end
            end
            S_READY: begin
               if (auto_boot) begin // see R14
                  o_flash_read <= 1'b1;
                  state <= S_FLASH;
               end else begin
                  state <= S_HOST;
               end
            end
            S_FLASH: begin
               if (i_flash_valid && i_flash_last) begin // see R3
                  o_flash_read <= 1'b0;
                  state <= S_CFG;
               end
            end
            S_HOST: begin
               // The host programs registers itself, so no commit step.
               if (i_host_done) begin // see R21
                  o_event_valid <= 1'b1;
                  o_event_code <= EV_BOOT_DONE;
                  o_host_interrupt_out_n <= 1'b1;
                  state <= S_RUN;
               end
            end
            S_CFG: begin
               o_cfg_commit <= 1'b1; // see R20, R4
               o_event_valid <= 1'b1;
               o_event_code <= EV_BOOT_DONE;
               o_host_interrupt_out_n <= 1'b1;
               state <= S_RUN;
            end
            S_RUN: begin
               o_run <= 1'b1; // see R20
            end
            default: begin
               state <= S_STRAP;
            end
         endcase
         if (boot_cnt == BOOT_LAST && !o_boot_timeout && auto_boot) begin
            o_event_valid <= 1'b1; // see R5
            o_event_code <= EV_TIMEOUT;
         end
      end
   end

   // ------------------------------------------------------------
   // Image writes into program RAM and configuration registers.
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pram_we <= 1'b0;
         o_cfg_we <= 1'b0;
         o_pram_addr <= '0;
         o_cfg_addr <= '0;
         o_wr_data <= '0;
      end else if (i_ce) begin
         o_pram_addr <= next_pram_addr;
         o_cfg_addr <= next_cfg_addr;
         o_pram_we <= wr_valid & ~wr_cfg; // see R3
         o_cfg_we <= wr_valid & wr_cfg; // see R4
         if (wr_valid) begin
            o_wr_data <= wr_word;
         end
      end
   end

   // ------------------------------------------------------------
   // Host port detection and boot master lock.
   // ------------------------------------------------------------
   // The clock pin is sampled at the system rate, so only edge counts
   // are taken here; the shift path itself lives in the slave port.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sclk_q <= 1'b0;
         sclk_edges <= 2'h0;
         o_hbi_spi_mode <= 1'b0;
         o_boot_master_set <= 1'b0;
         o_boot_master_spi <= 1'b0;
      end else if (i_ce) begin
         sclk_q <= i_host_bus_interface_sclk;
         if (sclk_rise && sclk_edges != SPI_EDGES) begin
            sclk_edges <= sclk_edges + 1'b1;
         end
         if (sclk_rise && sclk_edges == SPI_EDGES - 1'b1) begin
            o_hbi_spi_mode <= 1'b1; // see R16, R6
         end
         if (state == S_HOST && !o_boot_master_set) begin // see R15
            if (sclk_rise && sclk_edges == SPI_EDGES - 1'b1) begin
               o_boot_master_set <= 1'b1;
               o_boot_master_spi <= 1'b1;
            end else if (i_host_bus_interface_i2c_start) begin
               o_boot_master_set <= 1'b1;
               o_boot_master_spi <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Boot time watchdog.
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         boot_cnt <= '0;
         o_boot_timeout <= 1'b0;
      end else if (i_ce && state != S_RUN && !o_boot_timeout) begin
         boot_cnt <= boot_cnt + 1'b1;
         if (boot_cnt == BOOT_LAST && auto_boot) begin
            o_boot_timeout <= 1'b1; // see R5
         end
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   sequence s_locked_step;
      state == S_PLL && i_pll_locked && i_ce;
   endsequence
   sequence s_ready_shown;
      o_event_valid && o_event_code == EV_READY && !o_host_interrupt_out_n;
   endsequence

   chk_flash_only_auto: assert property (@(posedge i_clk) // see R21
      disable iff (i_rst) o_flash_read |-> auto_boot)
      else $error("Flash read outside auto boot.");
   chk_regulator_strap: assert property (@(posedge i_clk) // see R10
      disable iff (i_rst) o_core_reg_en |-> !external_supply_select_q)
      else $error("Regulator on with external supply.");
   chk_pll_after_supply: assert property (@(posedge i_clk) // see R11
      disable iff (i_rst) $rose(o_pll_en) |-> $past(i_supply_good))
      else $error("PLL enabled before supply good.");
   chk_ready_event: assert property (@(posedge i_clk) // see R13
      disable iff (i_rst) s_locked_step |=> s_ready_shown)
      else $error("Ready event or interrupt missing.");
   chk_flash_after_lock: assert property (@(posedge i_clk) // see R14
      disable iff (i_rst)
      (state == S_READY && i_ce && auto_boot) |=> o_flash_read)
      else $error("Flash read did not start.");
   chk_spi_two_edges: assert property (@(posedge i_clk) // see R16
      disable iff (i_rst)
      (sclk_rise && i_ce && sclk_edges == 2'h1) |=> o_hbi_spi_mode)
      else $error("SPI mode not taken after two edges.");
   chk_master_locked: assert property (@(posedge i_clk) // see R15
      disable iff (i_rst)
      o_boot_master_set |=> o_boot_master_set && $stable(o_boot_master_spi))
      else $error("Boot master changed.");
   chk_reserved_clock: assert property (@(posedge i_clk) // see R22
      disable iff (i_rst) o_pll_en |-> o_pll_ref_sel != CLK_RSVD)
      else $error("Reserved clock reference in use.");
   chk_commit_before_run: assert property (@(posedge i_clk) // see R20
      disable iff (i_rst)
      ($rose(o_run) && auto_boot) |-> $past(o_cfg_commit))
      else $error("Run without configuration commit.");
   chk_sense_stable: assert property (@(posedge i_clk) // see R18
      disable iff (i_rst) (state != S_STRAP) |=> $stable(o_boot_sense))
      else $error("Boot sense changed after sampling.");
   chk_reset_float: assert property (@(posedge i_clk) // see R17
      i_rst |=> !o_host_interrupt_out_oe)
      else $error("Interrupt pin driven in reset.");
endmodule // bs_boot_sequencer

// File: rtl/bs_pkg.sv
// Function
// R1: Auto boot reads Flash; host boot uses host port.
// R2: Boot mode comes from a strap input.
// R3: Image holds firmware and a configuration record.
// R4: Configuration record writes every user register.
// R5: Auto boot from Flash completes within one second.
// R6: Host SPI clock kept within the slave rate limit.
// R7: Host I2C clock kept within its rate limit.
// R8: Host should prefer SPI when boot time matters.
// R9: System supplies a stable clock before reset release.
// R10: Core regulator enabled only when supply select low.
// R11: PLL enabled only after core supply is good.
// R12: PLL reference from straps; wait for lock.
// R13: Ready posts an event and pulls interrupt low.
// R14: Auto boot starts Flash reads after PLL lock.
// R15: First host port to start owns the download.
// R16: Two host clock cycles select SPI, else I2C.
// R17: In reset, tristate outputs float; high means run.
// R18: Straps sampled at boot into boot-sense bits.
// R19: Strap decode: boot, crystal, 8k, 16k, reserved.
// R20: Auto boot commits configuration, then runs firmware.
// R21: Host boot never touches Flash; waits for host.
// R22: Reserved clock code falls back to crystal, reported.
package bs_pkg;
   // ------------------------------------------------------------
   // Data path widths.
   // ------------------------------------------------------------
   localparam int PRAM_AW = 16;
   localparam int CFG_AW = 12;
   localparam int DATA_W = 32;
   // ------------------------------------------------------------
   // Strap decode and boot-sense layout.
   // ------------------------------------------------------------
   localparam logic [1:0] CLK_XTAL = 2'h0;
   localparam logic [1:0] CLK_FS8K = 2'h1;
   localparam logic [1:0] CLK_FS16K = 2'h2;
   localparam logic [1:0] CLK_RSVD = 2'h3;
   localparam int SENSE_BOOT_BIT = 2;
   localparam logic [2:0] SENSE_RST = 3'h0;
   // ------------------------------------------------------------
   // Event codes.
   // ------------------------------------------------------------
   localparam logic [3:0] EV_NONE = 4'h0;
   localparam logic [3:0] EV_READY = 4'h1;
   localparam logic [3:0] EV_CLK_FALLBACK = 4'h2;
   localparam logic [3:0] EV_BOOT_DONE = 4'h3;
   localparam logic [3:0] EV_TIMEOUT = 4'h4;
   // ------------------------------------------------------------
   // Timing.
   // ------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 20000;
   localparam int BOOT_LIMIT_MS = 1000;
   localparam int BOOT_LIMIT_CYC = BOOT_LIMIT_MS * CLK_FREQ_KHZ;
   localparam int BOOT_CNT_W = 25;
   localparam logic [1:0] SPI_EDGES = 2'h2;
   // ------------------------------------------------------------
   // Sequencer states.
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      S_STRAP = 8'h01,
      S_SUPPLY = 8'h02,
      S_PLL = 8'h04,
      S_READY = 8'h08,
      S_FLASH = 8'h10,
      S_HOST = 8'h20,
      S_CFG = 8'h40,
      S_RUN = 8'h80
   } bs_state_t;
endpackage

// File: tb/bs_host_model.sv
`timescale 1ns/100ps
module bs_host_model import bs_pkg::*; (
   // Clock.
   input wire logic i_clk,
   // Host port pins and download words.
   output logic o_sclk,
   output logic o_i2c_start,
   output logic o_valid,
   output logic o_cfg,
   output logic [DATA_W-1:0] o_data,
   output logic o_done
);
   // Pins idle at time zero; the serial clock rests low between frames.
   initial begin
      o_sclk = 1'b0;
      o_i2c_start = 1'b0;
      o_valid = 1'b0;
      o_cfg = 1'b0;
      o_data = '0;
      o_done = 1'b0;
   end
   // Whole serial clock periods at half the bench clock rate.
   task automatic sclk_cycles(input int n);
      repeat (n) begin
         @(negedge i_clk);
         o_sclk = 1'b1;
         @(negedge i_clk);
         o_sclk = 1'b0;
      end
   endtask
   // A start condition as the slave port reports it.
   task automatic i2c_begin();
      @(negedge i_clk);
      o_i2c_start = 1'b1;
      @(negedge i_clk);
      o_i2c_start = 1'b0;
   endtask
   // One word after a random stall; released data is inverted, not stale.
   task automatic word(input logic c, input logic [DATA_W-1:0] d);
      repeat ($urandom % 4) @(negedge i_clk);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_cfg = c;
      o_data = d;
      @(negedge i_clk);
      o_valid = 1'b0;
      o_cfg = ~c;
      o_data = ~d;
   endtask
   // The download is complete.
   task automatic finish();
      @(negedge i_clk);
      o_done = 1'b1;
      @(negedge i_clk);
      o_done = 1'b0;
   endtask
endmodule // bs_host_model

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench import bs_pkg::*; ;
   logic clk, rst, ext, sboot, sup, lock, fv, fc, fl, sclk, hst, hv, hc, hd;
   logic [1:0] sck, pref;
   logic [DATA_W-1:0] fd, hdat, wd;
   logic reg_en, pll_en, fr, spim, mset, mspi, tmo, run, evv, int_n, ioe;
   logic pwe, cwe, cmt, ce;
   logic [2:0] sense;
   logic [3:0] evc;
   logic [PRAM_AW-1:0] pad;
   logic [CFG_AW-1:0] cad;
   logic [32:0] e;
   int err_count, comparisons, pa, ca, ncm;
   logic [32:0] wq[$];
   logic [3:0] evq[$];
   // Bench clock, 50 ns period.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Short boot limit keeps the overrun case brief.
   bs_boot_sequencer #(.BOOT_LIMIT(200)) DUT (
      .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_external_supply_select(ext),
      .i_strap_boot(sboot), .i_strap_clk(sck), .i_supply_good(sup),
      .i_pll_locked(lock), .i_host_bus_interface_sclk(sclk),
      .i_host_bus_interface_i2c_start(hst), .i_host_valid(hv),
      .i_host_cfg(hc), .i_host_data(hdat), .i_host_done(hd),
      .i_flash_valid(fv), .i_flash_cfg(fc), .i_flash_data(fd),
      .i_flash_last(fl), .o_core_reg_en(reg_en), .o_pll_en(pll_en),
      .o_pll_ref_sel(pref), .o_boot_sense(sense), .o_flash_read(fr),
      .o_hbi_spi_mode(spim), .o_boot_master_set(mset),
      .o_boot_master_spi(mspi), .o_boot_timeout(tmo), .o_run(run),
      .o_event_valid(evv), .o_event_code(evc),
      .o_host_interrupt_out_n(int_n), .o_host_interrupt_out_oe(ioe),
      .o_pram_we(pwe), .o_pram_addr(pad), .o_cfg_we(cwe), .o_cfg_addr(cad),
      .o_wr_data(wd), .o_cfg_commit(cmt));
   bs_host_model host (.i_clk(clk), .o_sclk(sclk), .o_i2c_start(hst),
      .o_valid(hv), .o_cfg(hc), .o_data(hdat), .o_done(hd));
   task automatic stop_test();
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] g, input logic [32:0] x,
                      input string m);
      comparisons++;
      if (g !== x) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // Bounded wait; running out ends the run as a mismatch.
   task automatic wait_for(ref logic s, input logic v, input int n);
      repeat (n) if (s !== v) @(negedge clk);
      if (s !== v) begin
         err_count++;
         $display("wrong value at %0t: wait ran out", $time);
         stop_test();
      end
   endtask
   // Each write and event is popped from the model queues and compared.
   // Outputs are read mid-cycle, well away from the edge that moves them.
   always @(negedge clk) begin
      if (pwe === 1'b1 || cwe === 1'b1) begin
         e = (wq.size() != 0) ? wq.pop_front() : 33'h0;
         chk({cwe, wd}, e, "write data");
         chk(e[32] ? cad : pad, e[32] ? ca : pa, "write addr");
         if (e[32]) ca++;
         else pa++;
      end
      if (evv === 1'b1) begin
         e = (evq.size() != 0) ? 33'(evq.pop_front()) : 33'h1F;
         chk(evc, e, "event code");
      end
      if (cmt === 1'b1) ncm++;
   end
   task automatic fword(input logic [32:0] w, input logic l);
      repeat ($urandom % 4) @(negedge clk);
      @(negedge clk);
      fv = 1'b1;
      {fc, fd} = w;
      fl = l;
      @(negedge clk);
      fv = 1'b0;
      fl = 1'b0;
      {fc, fd} = ~w;
   endtask
   // Five words of mixed segments, the last one closing a Flash image.
   task automatic load(input logic f);
      logic [32:0] w;
      for (int i = 0; i < 5; i++) begin
         w = {1'($urandom), $urandom};
         wq.push_back(w);
         if (f) fword(w, i == 4);
         else host.word(w[32], w[31:0]);
      end
   endtask
   task automatic boot(input logic au, input logic [1:0] ck, input logic md);
      @(negedge clk);
      rst = 1'b1;
      sboot = au;
      sck = ck;
      ext = 1'($urandom);
      sup = 1'b0;
      lock = 1'b0;
      repeat (4) @(negedge clk);
      chk(ioe, 0, "pin driven in reset");
      chk(int_n, 1, "interrupt in reset");
      rst = 1'b0;
      pa = 0;
      ca = 0;
      ncm = 0;
      if (ck == CLK_RSVD) evq.push_back(EV_CLK_FALLBACK);
      evq.push_back(EV_READY);
      repeat (5) @(negedge clk);
      chk(sense, {au, ck}, "boot sense");
      chk(reg_en, !ext, "regulator");
      chk(pref, (ck == CLK_RSVD) ? CLK_XTAL : ck, "pll ref");
      chk(pll_en, 0, "pll before supply");
      // Supply good while the enable is low must not move the sequencer.
      ce = 1'b0;
      sup = 1'b1;
      repeat (3) @(negedge clk);
      chk(pll_en, 0, "clock enable low");
      ce = 1'b1;
      wait_for(pll_en, 1'b1, 5);
      repeat (3) @(negedge clk);
      chk(int_n, 1, "ready before lock");
      lock = 1'b1;
      wait_for(int_n, 1'b0, 5);
      chk(ioe, 1, "pin released");
      if (au) begin
         wait_for(fr, 1'b1, 5);
         if (md) begin
            evq.push_back(EV_TIMEOUT);
            repeat (250) @(negedge clk);
            chk(tmo, 1, "boot limit");
         end
      end else begin
         chk(fr, 0, "flash in host boot");
         host.sclk_cycles(md ? 1 : 2);
         if (md) host.i2c_begin();
         wait_for(mset, 1'b1, 6);
         chk(spim, !md, "port kind");
         if (md) host.sclk_cycles(2);
         else host.i2c_begin();
         chk(mspi, !md, "boot master");
         fword({1'($urandom), $urandom}, 1'b0);
      end
      evq.push_back(EV_BOOT_DONE);
      load(au);
      if (!au) host.finish();
      wait_for(run, 1'b1, 10);
      chk(ncm, au, "commit");
      chk(int_n, 1, "interrupt after boot");
      chk(tmo, au & md, "boot limit flag");
      chk(evq.size(), 0, "missing event");
   endtask
   // Main sequence: every clock code in auto boot, both host ports, overrun.
   initial begin
      err_count = 0;
      comparisons = 0;
      rst = 1'b1;
      {ext, sboot, sup, lock, fv, fc, fl} = '0;
      ce = 1'b1;
      sck = '0;
      fd = '0;
      void'($urandom(32'h9BC6));
      repeat (4) @(negedge clk);
      for (int k = 0; k < 4; k++) boot(1'b1, 2'(k), 1'b0);
      boot(1'b0, 2'($urandom), 1'b0);
      boot(1'b0, 2'($urandom), 1'b1);
      boot(1'b1, CLK_XTAL, 1'b1);
      stop_test();
   end
endmodule // testbench
